// File: rtl/mscp_map.svh
`ifndef MSCP_MAP_SVH
`define MSCP_MAP_SVH
`define MSCP_CLK_HZ 20000000
`define MSCP_BAUD_MIN 300
`define MSCP_BAUD_MAX 19200
`define MSCP_ADDR_MAX 7'd99
`define MSCP_MAX_UNITS 32
`define MSCP_DLY_SHORT_MIN_MS 2
`define MSCP_DLY_SHORT_MAX_MS 50
`define MSCP_DLY_LONG_MIN_MS 50
`define MSCP_DLY_LONG_MAX_MS 100
`define MSCP_CYC_PER_MS (`MSCP_CLK_HZ / 1000)
`define MSCP_FIFO_DEPTH 32
`endif

// File: rtl/mscp_pkg.sv
package mscp_pkg;
  typedef enum logic [1:0] {
    MSCP_PAR_NONE = 2'h0,
    MSCP_PAR_ODD = 2'h1,
    MSCP_PAR_EVEN = 2'h2
  } mscp_par_t;
  typedef struct packed {
    logic [15:0] baud_div;
    logic data8;
    mscp_par_t parity;
    logic multidrop;
    logic [6:0] node_addr;
    logic [6:0] reply_dly_ms;
  } mscp_cfg_t;
endpackage : mscp_pkg

// File: rtl/mscp_fifo.sv
module mscp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule : mscp_fifo

// File: rtl/mscp_port.sv
// Behaviour
// - Bit rate divider (16 bits at 20 MHz) covers about 305 to 19200 baud; peers must match.
// - Seven or eight data bits; odd, even or no parity configured.
// - Node address 0 to 99; at most 32 units per bus.
// - Multi-drop reply waits configured delay, 2-50 ms or 50-100 ms.
// - Point-to-point sending pauses while receive line held at space.
// - Shared bus driven only while not receiving.
// - Point-to-point link also half duplex; no reply during reception.
// - Terminal equipment: send on transmit line, receive on receive line.
// - Start bit, data LSB first, optional parity, stop bit.
// - Receive parity ignored; transmit odd, even or mark parity.
// - Seven bits without parity sends two stop bits.
module mscp_port
  import mscp_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire mscp_cfg_t cfg,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic tx_oe,
  output logic [DATA_W-1:0] rx_data,
  output logic rx_strobe,
  input wire logic cmd_done,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  output logic tx_busy,
  output logic addr_bad
);
`include "mscp_map.svh"
  typedef enum logic [3:0] {
    MSCP_TX_IDLE = 4'b0001,
    MSCP_TX_WAIT = 4'b0010,
    MSCP_TX_SHIFT = 4'b0100,
    MSCP_TX_HOLD = 4'b1000
  } mscp_txst_t;

  function automatic logic [15:0] bit_limit(input logic [15:0] div);
    bit_limit = (div == '0) ? 16'h0000 : div - 16'h0001;
  endfunction : bit_limit

  logic [2:0] rx_sync_q;
  logic rx_line_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sync_q <= 3'h7;
      rx_line_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], rx_pin};
      if (rx_sync_q[1] == rx_sync_q[2]) begin
        rx_line_q <= rx_sync_q[2];
      end
    end
  end

  // check, informative for the meter's panel logic
  assign addr_bad = (cfg.node_addr > `MSCP_ADDR_MAX);

  // Receiver, parity bit sampled but discarded
  logic rx_act_q;
  logic [15:0] rx_cnt_q;
  logic [3:0] rx_bit_q;
  logic [DATA_W-1:0] rx_sh_q;
  logic [3:0] rx_nbits;
  logic [3:0] rx_stop;
  logic [15:0] bit_lim;
  assign rx_nbits = cfg.data8 ? 4'h8 : 4'h7;
  // Stop position skips the parity or mark slot, so the strobe lands in the stop bit
  assign rx_stop = rx_nbits + (((cfg.parity != MSCP_PAR_NONE) || !cfg.data8) ? 4'h2 : 4'h1);
  assign bit_lim = bit_limit(cfg.baud_div);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_act_q <= 1'b0;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_data <= '0;
      rx_strobe <= 1'b0;
    end else begin
      rx_strobe <= 1'b0;
      if (!rx_act_q) begin
        if (!rx_line_q && !(cfg.multidrop ? tx_oe : tx_busy)) begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= {1'b0, bit_lim[15:1]};
          rx_bit_q <= '0;
        end
      end else if (rx_cnt_q != '0) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= bit_limit(cfg.baud_div);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_line_q) begin
          rx_act_q <= 1'b0;
        end else if (rx_bit_q != 4'h0 && rx_bit_q <= rx_nbits) begin
          rx_sh_q <= {rx_line_q, rx_sh_q[DATA_W-1:1]};
        end else if (rx_bit_q == rx_stop) begin
          rx_act_q <= 1'b0;
          rx_strobe <= 1'b1;
          rx_data <= cfg.data8 ? rx_sh_q : {1'b0, rx_sh_q[DATA_W-1:1]};
        end
      end
    end
  end

  // Millisecond tick and reply delay
  logic [15:0] ms_cnt_q;
  logic ms_tick;
  logic [6:0] dly_q;
  logic reply_ok_q;
  assign ms_tick = (ms_cnt_q == 16'(`MSCP_CYC_PER_MS - 1));
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_q <= '0;
      reply_ok_q <= 1'b1;
    end else if (cmd_done) begin
      dly_q <= cfg.multidrop ? cfg.reply_dly_ms : 7'h00;
      reply_ok_q <= !cfg.multidrop;
    end else if (!reply_ok_q && ms_tick) begin
      if (dly_q <= 7'h01) begin
        reply_ok_q <= 1'b1;
      end
      dly_q <= dly_q - 7'h01;
    end
  end

  // Transmit buffer
  logic f_valid;
  logic f_ready;
  logic [DATA_W-1:0] f_data;
  mscp_fifo #(.WIDTH(DATA_W), .DEPTH(`MSCP_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Transmitter
  mscp_txst_t st_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bit_q;
  logic [11:0] tx_sh_q;
  logic [3:0] tx_len_q;
  logic busy_line;
  logic [11:0] frame;
  logic [3:0] frame_len;
  logic par_bit;
  assign busy_line = !cfg.multidrop && !rx_line_q;
  always_comb begin
    par_bit = cfg.data8 ? ^f_data : ^f_data[6:0];
    unique case (cfg.parity)
      MSCP_PAR_ODD: par_bit = ~par_bit;
      MSCP_PAR_EVEN: par_bit = par_bit;
      default: par_bit = 1'b1;
    endcase
    frame = 12'hfff;
    if (cfg.data8) begin
      frame[8:0] = {f_data, 1'b0};
      frame[9] = par_bit;
      frame_len = (cfg.parity == MSCP_PAR_NONE) ? 4'ha : 4'hb;
    end else begin
      frame[7:0] = {f_data[6:0], 1'b0};
      frame[8] = par_bit; // parity bit, or mark bit doubling as first stop when parity is none
      frame_len = 4'ha;
    end
  end
  // Idle-high line also keeps a bus start bit from racing our own start bit
  assign f_ready = (st_q == MSCP_TX_WAIT) && !rx_act_q && !busy_line && rx_line_q && reply_ok_q;
  assign tx_busy = (st_q != MSCP_TX_IDLE);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= MSCP_TX_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= 12'hfff;
      tx_len_q <= '0;
      tx_pin <= 1'b1;
      tx_oe <= 1'b0;
    end else begin
      unique case (st_q)
        MSCP_TX_IDLE: begin
          tx_oe <= !cfg.multidrop;
          if (f_valid) begin
            st_q <= MSCP_TX_WAIT;
          end
        end
        MSCP_TX_WAIT: begin
          if (f_ready) begin
            st_q <= MSCP_TX_SHIFT;
            tx_sh_q <= frame >> 1;
            tx_pin <= frame[0];
            tx_oe <= 1'b1;
            tx_len_q <= frame_len;
            tx_bit_q <= 4'h1;
            tx_cnt_q <= bit_limit(cfg.baud_div);
          end else if (!f_valid) begin
            st_q <= MSCP_TX_IDLE;
          end
        end
        MSCP_TX_SHIFT: begin
          if (tx_cnt_q != '0) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
          end else if (tx_bit_q == tx_len_q) begin
            st_q <= MSCP_TX_HOLD;
          end else begin
            tx_pin <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[11:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            tx_cnt_q <= bit_limit(cfg.baud_div);
          end
        end
        MSCP_TX_HOLD: begin
          tx_pin <= 1'b1;
          tx_oe <= !cfg.multidrop || f_valid;
          st_q <= f_valid ? MSCP_TX_WAIT : MSCP_TX_IDLE;
        end
      endcase
    end
  end

  tx_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    f_ready |=> !tx_pin && tx_oe && st_q == MSCP_TX_SHIFT) else $error("start bit missing");
  busy_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    busy_line |-> !f_ready) else $error("frame started while busy");
  half_duplex_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rx_act_q |-> !f_ready) else $error("reply during reception");
  bus_release_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg.multidrop && $rose(rx_act_q) |-> !tx_oe) else $error("bus driven while receiving");
  delay_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cmd_done && cfg.multidrop && cfg.reply_dly_ms != 7'h00 |=> !reply_ok_q) else $error("delay skipped");
  delay_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !reply_ok_q |-> !f_ready) else $error("reply before delay");
  stop_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == MSCP_TX_HOLD |=> tx_pin) else $error("stop level wrong");
  rx_level_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rx_strobe |-> $past(rx_act_q)) else $error("strobe without frame");
endmodule : mscp_port

// File: verif/mscp_host_model.sv
module mscp_host_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic busy,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic send_q = 1'b0;
  logic bit_q = 1'b1;
  // Idle line sits at mark; busy holds it at space
  assign line = busy ? 1'b0 : (send_q ? bit_q : 1'b1);
  task automatic send_char(input logic [7:0] d, input int nb, input logic par);
    send_q <= 1'b1;
    for (int i = 0; i < nb + 3; i++) begin
      bit_q <= (i == 0) ? 1'b0 : (i <= nb) ? d[i-1] : (i == nb + 1) ? par : 1'b1;
      repeat (BIT_CYC) @(posedge ref_clk);
    end
    send_q <= 1'b0;
  endtask : send_char
endmodule : mscp_host_model

// File: verif/meter_serial_comm_port_test.sv
module meter_serial_comm_port_test;
  import mscp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BC = 16;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  mscp_cfg_t cfg = '{16'h0010, 1'b1, MSCP_PAR_NONE, 1'b0, 7'h00, 7'h02};
  logic rx_pin, tx_pin, tx_oe, rx_strobe, tx_ready, tx_busy, addr_bad;
  logic [7:0] rx_data;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic cmd_done = 1'b0;
  logic busy = 1'b0;
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 31618;
  int cyc = 0;
  logic [7:0] q [40];
  mscp_port u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg(cfg), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .tx_oe(tx_oe), .rx_data(rx_data), .rx_strobe(rx_strobe), .cmd_done(cmd_done), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_busy(tx_busy), .addr_bad(addr_bad));
  mscp_host_model #(.BIT_CYC(BC)) u_host (.ref_clk(ref_clk), .busy(busy), .line(rx_pin));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic exp_par(input logic [7:0] d);
    if (cfg.parity == MSCP_PAR_ODD) return ~^d;
    if (cfg.parity == MSCP_PAR_EVEN) return ^d;
    return 1'b1;
  endfunction : exp_par
  task automatic push(input logic [7:0] d);
    tx_data <= d;
    tx_valid <= 1'b1;
    @(posedge ref_clk);
    while (tx_ready !== 1'b1) @(posedge ref_clk);
  endtask : push
  task automatic expect_frame(input logic [7:0] d);
    int nb;
    nb = cfg.data8 ? 8 : 7;
    while (tx_pin !== 1'b0) @(posedge ref_clk);
    repeat (BC / 2) @(posedge ref_clk);
    chk(tx_pin, 1'b0);
    chk(tx_oe, 1'b1);
    for (int i = 0; i < nb; i++) begin
      repeat (BC) @(posedge ref_clk);
      chk(tx_pin, d[i]);
    end
    if (!(cfg.data8 && cfg.parity == MSCP_PAR_NONE)) begin
      repeat (BC) @(posedge ref_clk);
      chk(tx_pin, exp_par(d));
    end
    repeat (BC) @(posedge ref_clk);
    chk(tx_pin, 1'b1);
  endtask : expect_frame
  initial begin
    logic [7:0] d;
    logic [7:0] e;
    int n;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    chk(tx_pin, 1'b1);
    chk(addr_bad, 1'b0);
    cfg.node_addr <= 7'd99;
    @(posedge ref_clk);
    #1 chk(addr_bad, 1'b0);
    @(posedge ref_clk);
    cfg.node_addr <= 7'd100;
    @(posedge ref_clk);
    #1 chk(addr_bad, 1'b1);
    for (int m = 0; m < 6; m++) begin
      cfg.data8 <= m[0];
      cfg.parity <= mscp_par_t'(m / 2);
      d = $random(seed);
      @(posedge ref_clk);
      if (!cfg.data8) d[7] = 1'b0;
      push(d);
      push(~d & (cfg.data8 ? 8'hff : 8'h7f));
      tx_valid <= 1'b0;
      expect_frame(d);
      expect_frame(~d & (cfg.data8 ? 8'hff : 8'h7f));
    end
    for (int m = 0; m < 2; m++) begin
      cfg.data8 <= m[0];
      d = $random(seed);
      e = $random(seed) & 8'h7f;
      @(posedge ref_clk);
      fork
        u_host.send_char(d, 7 + m, $random(seed));
        begin
          repeat (30) @(posedge ref_clk);
          push(e);
          tx_valid <= 1'b0;
          n = 0;
          repeat (100) begin
            @(posedge ref_clk);
            if (tx_pin !== 1'b1) n++;
          end
          chk(n, 0);
          expect_frame(e);
        end
        begin
          while (rx_strobe !== 1'b1) @(posedge ref_clk);
          chk(rx_data, m ? d : {1'b0, d[6:0]});
        end
      join
    end
    cfg.parity <= MSCP_PAR_EVEN;
    busy <= 1'b1;
    repeat (10) @(posedge ref_clk);
    n = 0;
    tx_valid <= 1'b1;
    while (n < 40) begin
      d = $random(seed);
      tx_data <= d;
      @(posedge ref_clk);
      if (tx_ready !== 1'b1) break;
      q[n] = d;
      n++;
    end
    tx_valid <= 1'b0;
    chk(n >= 32, 1'b1);
    repeat (200) @(posedge ref_clk);
    chk(tx_pin, 1'b1);
    busy <= 1'b0;
    for (int i = 0; i < n; i++) expect_frame(q[i]);
    cfg.multidrop <= 1'b1;
    repeat (40) @(posedge ref_clk);
    chk(tx_oe, 1'b0);
    cmd_done <= 1'b1;
    @(posedge ref_clk);
    cmd_done <= 1'b0;
    d = $random(seed);
    push(d);
    tx_valid <= 1'b0;
    n = 0;
    repeat (20000) begin
      @(posedge ref_clk);
      if (tx_pin !== 1'b1) n++;
    end
    chk(n, 0);
    expect_frame(d);
    complete_run();
  end
endmodule : meter_serial_comm_port_test
